/* core/cbe_regs.svh */
// register offsets, command field positions and reset values of the branch and
// load/store execution block; included by the package user, definitions only
`ifndef CBE_REGS_SVH
`define CBE_REGS_SVH

// apb byte offsets
`define CBE_CMD_OFS        12'h000
`define CBE_OPERAND_OFS    12'h004
`define CBE_STATUS_OFS     12'h008
`define CBE_FLAGS_OFS      12'h00C
`define CBE_PC_OFS         12'h010
`define CBE_RF_BASE_OFS    12'h080
`define CBE_RF_LAST_OFS    12'h0FC

// command word fields
`define CBE_CMD_OP_LSB     0
`define CBE_CMD_OP_MSB     3
`define CBE_CMD_D_LSB      4
`define CBE_CMD_D_MSB      8
`define CBE_CMD_R_LSB      9
`define CBE_CMD_R_MSB      13
`define CBE_CMD_PTR_LSB    14
`define CBE_CMD_PTR_MSB    15
`define CBE_CMD_MODE_LSB   16
`define CBE_CMD_MODE_MSB   17
`define CBE_CMD_SEL_LSB    18
`define CBE_CMD_SEL_MSB    20
`define CBE_CMD_POL_BIT    21

// status word fields
`define CBE_STAT_BUSY_BIT  0
`define CBE_STAT_TAKEN_BIT 1

// status flag positions
`define CBE_FLAG_C         0
`define CBE_FLAG_Z         1
`define CBE_FLAG_N         2
`define CBE_FLAG_V         3
`define CBE_FLAG_S         4
`define CBE_FLAG_H         5
`define CBE_FLAG_T         6
`define CBE_FLAG_I         7

// pointer pairs: low byte in the lower register
`define CBE_PTR_X_LOW      5'h1A
`define CBE_PTR_Y_LOW      5'h1C
`define CBE_PTR_Z_LOW      5'h1E

// reset values
`define CBE_PC_RST         16'h0000
`define CBE_FLAGS_RST      8'h00
`define CBE_OPERAND_RST    16'h0000

`endif

/* core/cbe_pkg.sv */
// types of the branch and load/store execution block
// assumes nothing beyond a SystemVerilog compiler
package cbe_pkg;

    typedef enum logic [3:0] {
        CBE_OP_BRANCH       = 4'h0,
        CBE_OP_COPY         = 4'h1,
        CBE_OP_COPY_PAIR    = 4'h2,
        CBE_OP_LOAD_IMM     = 4'h3,
        CBE_OP_LOAD_DIRECT  = 4'h4,
        CBE_OP_LOAD_IND     = 4'h5,
        CBE_OP_STORE_DIRECT = 4'h6,
        CBE_OP_STORE_IND    = 4'h7
    } cbe_op_type;

    typedef enum logic [1:0] {
        CBE_MODE_PLAIN    = 2'h0,
        CBE_MODE_POST_INC = 2'h1,
        CBE_MODE_PRE_DEC  = 2'h2,
        CBE_MODE_DISP     = 2'h3
    } cbe_mode_type;

    // gray path idle -> first -> last
    typedef enum logic [1:0] {
        CBE_ST_IDLE  = 2'h0,
        CBE_ST_FIRST = 2'h1,
        CBE_ST_LAST  = 2'h3
    } cbe_state_type;

    typedef struct packed {
        cbe_state_type      state;
        logic [31:0][7:0]   regs;
        logic [7:0]         flags;
        logic [15:0]        pc;
        cbe_op_type         op;
        logic [4:0]         dst;
        logic [4:0]         src;
        logic [1:0]         ptr;
        cbe_mode_type       mode;
        logic [2:0]         sel;
        logic               pol;
        logic [15:0]        operand;
        logic               taken;
        logic [15:0]        addr;
        logic [7:0]         wdata;
        logic               wr;
        logic               rd;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } cbe_state_reg_type;

endpackage

/* core/cbe_exec.sv */
// branch, register copy and data-space load/store execution unit with its
// register file, status flags and program counter, commanded over apb.
// assumes a data memory that answers reads combinationally from the address
// outputs and takes writes at the clock edge while the write strobe is high.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "cbe_regs.svh"

module cbe_exec #(
    parameter int DISP_W = 6
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic [31:0]      prdata_out,
    // data memory
    input  wire logic [7:0]  dmem_rdata_in,
    output logic [15:0]      dmem_addr_out,
    output logic [7:0]       dmem_wdata_out,
    output logic             dmem_wr_out,
    output logic             dmem_rd_out,
    // core state
    output logic             busy_out,
    output logic [15:0]      pc_out
);

    initial begin
        if (DISP_W < 1 || DISP_W > 16) begin
            $error("cbe_exec: DISP_W must lie in 1..16");
        end
    end

    cbe_pkg::cbe_state_reg_type s_reg;
    cbe_pkg::cbe_state_reg_type s_next;
    logic                       busy_next;

    // pointer pair base register for a pointer select
    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        logic [4:0] b;
        b = `CBE_PTR_X_LOW;
        if (sel == 2'h1) begin
            b = `CBE_PTR_Y_LOW;
        end else if (sel == 2'h2) begin
            b = `CBE_PTR_Z_LOW;
        end
        return b;
    endfunction

    // branch condition from flags, with S formed as N xor V
    function automatic logic branch_taken(input logic [7:0] f, input logic [2:0] sel,
                                          input logic pol);
        logic v;
        v = f[sel];
        if (sel == 3'(`CBE_FLAG_S)) begin
            v = f[`CBE_FLAG_N] ^ f[`CBE_FLAG_V];
        end
        return v == pol;
    endfunction

    always_comb begin
        logic [11:0]             a;
        logic                    err;
        logic [31:0]             rdat;
        logic                    acc_wr;
        cbe_pkg::cbe_op_type     c_op;
        cbe_pkg::cbe_mode_type   c_mode;
        logic [1:0]              c_ptr;
        logic [4:0]              c_dst;
        logic [4:0]              c_src;
        logic [4:0]              base;
        logic [15:0]             pv;
        logic [15:0]             np;
        logic                    two;
        logic                    tk;
        logic                    illegal;
        a       = paddr_in;
        err     = 1'b0;
        rdat    = 32'h0000_0000;
        acc_wr  = 1'b0;
        c_op    = cbe_pkg::cbe_op_type'(pwdata_in[`CBE_CMD_OP_MSB:`CBE_CMD_OP_LSB]);
        c_mode  = cbe_pkg::cbe_mode_type'(pwdata_in[`CBE_CMD_MODE_MSB:`CBE_CMD_MODE_LSB]);
        c_ptr   = pwdata_in[`CBE_CMD_PTR_MSB:`CBE_CMD_PTR_LSB];
        c_dst   = pwdata_in[`CBE_CMD_D_MSB:`CBE_CMD_D_LSB];
        c_src   = pwdata_in[`CBE_CMD_R_MSB:`CBE_CMD_R_LSB];
        base    = 5'h00;
        pv      = 16'h0000;
        np      = 16'h0000;
        two     = 1'b0;
        tk      = 1'b0;
        illegal = 1'b0;
        s_next  = s_reg;
        s_next.pready = 1'b0;
        s_next.wr     = 1'b0;
        s_next.rd     = 1'b0;

        // command legality: unknown op, pointer 3, displacement on X, odd pair
        illegal = (pwdata_in[`CBE_CMD_OP_MSB] != 1'b0);
        if ((c_op == cbe_pkg::CBE_OP_LOAD_IND || c_op == cbe_pkg::CBE_OP_STORE_IND)
            && (c_ptr == 2'h3 || (c_mode == cbe_pkg::CBE_MODE_DISP && c_ptr == 2'h0))) begin
            illegal = 1'b1;
        end
        if (c_op == cbe_pkg::CBE_OP_COPY_PAIR && (c_dst[0] || c_src[0])) begin
            illegal = 1'b1;
        end

        // setup phase: decode, answer in the following access cycle
        if (psel_in && !penable_in) begin
            s_next.pready = 1'b1;
            if (a == `CBE_CMD_OFS) begin
                err = !pwrite_in || s_reg.state != cbe_pkg::CBE_ST_IDLE || illegal;
            end else if (a == `CBE_OPERAND_OFS) begin
                err  = pwrite_in && s_reg.state != cbe_pkg::CBE_ST_IDLE;
                rdat = {16'h0000, s_reg.operand};
            end else if (a == `CBE_STATUS_OFS) begin
                err  = pwrite_in;
                rdat[`CBE_STAT_BUSY_BIT]  = s_reg.state != cbe_pkg::CBE_ST_IDLE;
                rdat[`CBE_STAT_TAKEN_BIT] = s_reg.taken;
            end else if (a == `CBE_FLAGS_OFS) begin
                err  = pwrite_in && s_reg.state != cbe_pkg::CBE_ST_IDLE;
                rdat = {24'h00_0000, s_reg.flags};
            end else if (a == `CBE_PC_OFS) begin
                err  = pwrite_in && s_reg.state != cbe_pkg::CBE_ST_IDLE;
                rdat = {16'h0000, s_reg.pc};
            end else if (a >= `CBE_RF_BASE_OFS && a <= `CBE_RF_LAST_OFS && a[1:0] == 2'h0) begin
                err  = pwrite_in && s_reg.state != cbe_pkg::CBE_ST_IDLE;
                rdat = {24'h00_0000, s_reg.regs[a[6:2]]};
            end else begin
                err = 1'b1;
            end
            s_next.pslverr = err;
            s_next.prdata  = pwrite_in ? 32'h0000_0000 : (err ? 32'h0000_0000 : rdat);
        end

        // access edge: writes take effect only here, and only if not refused
        acc_wr = psel_in && penable_in && s_reg.pready && pwrite_in && !s_reg.pslverr;

        if (acc_wr) begin
            if (a == `CBE_OPERAND_OFS) begin
                s_next.operand = pwdata_in[15:0];
            end else if (a == `CBE_FLAGS_OFS) begin
                s_next.flags = pwdata_in[7:0];
            end else if (a == `CBE_PC_OFS) begin
                s_next.pc = pwdata_in[15:0];
            end else if (a >= `CBE_RF_BASE_OFS && a <= `CBE_RF_LAST_OFS) begin
                s_next.regs[a[6:2]] = pwdata_in[7:0];
            end else if (a == `CBE_CMD_OFS) begin
                s_next.op   = c_op;
                s_next.dst  = c_dst;
                s_next.src  = c_src;
                s_next.ptr  = c_ptr;
                s_next.mode = c_mode;
                s_next.sel  = pwdata_in[`CBE_CMD_SEL_MSB:`CBE_CMD_SEL_LSB];
                s_next.pol  = pwdata_in[`CBE_CMD_POL_BIT];
                tk = branch_taken(s_reg.flags, pwdata_in[`CBE_CMD_SEL_MSB:`CBE_CMD_SEL_LSB],
                                  pwdata_in[`CBE_CMD_POL_BIT]);
                s_next.taken = (c_op == cbe_pkg::CBE_OP_BRANCH) && tk;
                // taken branch, direct, pre-decrement and displaced take two cycles
                two = ((c_op == cbe_pkg::CBE_OP_BRANCH) && tk)
                      || c_op == cbe_pkg::CBE_OP_LOAD_DIRECT
                      || c_op == cbe_pkg::CBE_OP_STORE_DIRECT
                      || ((c_op == cbe_pkg::CBE_OP_LOAD_IND
                           || c_op == cbe_pkg::CBE_OP_STORE_IND)
                          && (c_mode == cbe_pkg::CBE_MODE_PRE_DEC
                              || c_mode == cbe_pkg::CBE_MODE_DISP));
                if (two) begin
                    s_next.state = cbe_pkg::CBE_ST_FIRST;
                end else begin
                    s_next.state = cbe_pkg::CBE_ST_LAST;
                    // one-cycle indirect access uses the pointer as it stands
                    base = ptr_base(c_ptr);
                    s_next.addr  = {s_reg.regs[base + 5'h01], s_reg.regs[base]};
                    s_next.wdata = s_reg.regs[c_src];
                    s_next.rd    = c_op == cbe_pkg::CBE_OP_LOAD_IND;
                    s_next.wr    = c_op == cbe_pkg::CBE_OP_STORE_IND;
                end
            end
        end

        // execution
        base = ptr_base(s_reg.ptr);
        pv   = {s_reg.regs[base + 5'h01], s_reg.regs[base]};
        unique case (s_reg.state)
            cbe_pkg::CBE_ST_IDLE: begin
            end
            cbe_pkg::CBE_ST_FIRST: begin
                s_next.state = cbe_pkg::CBE_ST_LAST;
                s_next.wdata = s_reg.regs[s_reg.src];
                if (s_reg.op == cbe_pkg::CBE_OP_LOAD_DIRECT
                    || s_reg.op == cbe_pkg::CBE_OP_STORE_DIRECT) begin
                    s_next.addr = s_reg.operand;
                end else if (s_reg.mode == cbe_pkg::CBE_MODE_PRE_DEC) begin
                    np = pv - 16'h0001;
                    s_next.regs[base]         = np[7:0];
                    s_next.regs[base + 5'h01] = np[15:8];
                    s_next.addr = np;
                end else begin
                    // unsigned displacement, pointer left as it is
                    np = 16'h0000;
                    np[DISP_W-1:0] = s_reg.operand[DISP_W-1:0];
                    s_next.addr = pv + np;
                end
                s_next.rd = s_reg.op == cbe_pkg::CBE_OP_LOAD_DIRECT
                            || s_reg.op == cbe_pkg::CBE_OP_LOAD_IND;
                s_next.wr = s_reg.op == cbe_pkg::CBE_OP_STORE_DIRECT
                            || s_reg.op == cbe_pkg::CBE_OP_STORE_IND;
            end
            cbe_pkg::CBE_ST_LAST: begin
                s_next.state = cbe_pkg::CBE_ST_IDLE;
                s_next.pc    = s_reg.pc + 16'h0001;
                unique case (s_reg.op)
                    cbe_pkg::CBE_OP_BRANCH: begin
                        if (s_reg.taken) begin
                            s_next.pc = s_reg.pc + s_reg.operand + 16'h0001;
                        end
                    end
                    cbe_pkg::CBE_OP_COPY: begin
                        s_next.regs[s_reg.dst] = s_reg.regs[s_reg.src];
                    end
                    cbe_pkg::CBE_OP_COPY_PAIR: begin
                        s_next.regs[{s_reg.dst[4:1], 1'b0}] = s_reg.regs[{s_reg.src[4:1], 1'b0}];
                        s_next.regs[{s_reg.dst[4:1], 1'b1}] =
                            s_reg.regs[{s_reg.src[4:1], 1'b1}];
                    end
                    cbe_pkg::CBE_OP_LOAD_IMM: begin
                        s_next.regs[s_reg.dst] = s_reg.operand[7:0];
                    end
                    cbe_pkg::CBE_OP_LOAD_DIRECT: begin
                        s_next.regs[s_reg.dst] = dmem_rdata_in;
                        s_next.pc = s_reg.pc + 16'h0002;
                    end
                    cbe_pkg::CBE_OP_STORE_DIRECT: begin
                        s_next.pc = s_reg.pc + 16'h0002;
                    end
                    cbe_pkg::CBE_OP_LOAD_IND: begin
                        s_next.regs[s_reg.dst] = dmem_rdata_in;
                    end
                    cbe_pkg::CBE_OP_STORE_IND: begin
                    end
                    default: begin
                    end
                endcase
                // post-increment after the access; pointer write wins over a load into it
                if ((s_reg.op == cbe_pkg::CBE_OP_LOAD_IND || s_reg.op == cbe_pkg::CBE_OP_STORE_IND)
                    && s_reg.mode == cbe_pkg::CBE_MODE_POST_INC) begin
                    np = pv + 16'h0001;
                    s_next.regs[base]         = np[7:0];
                    s_next.regs[base + 5'h01] = np[15:8];
                end
            end
            default: begin
                s_next.state = cbe_pkg::CBE_ST_IDLE;
            end
        endcase
        // no operation here writes the status flags
        busy_next = s_next.state != cbe_pkg::CBE_ST_IDLE;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_reg         <= '0;
            s_reg.state   <= cbe_pkg::CBE_ST_IDLE;
            s_reg.flags   <= `CBE_FLAGS_RST;
            s_reg.pc      <= `CBE_PC_RST;
            s_reg.operand <= `CBE_OPERAND_RST;
            busy_out      <= 1'b0;
        end else begin
            s_reg    <= s_next;
            busy_out <= busy_next;
        end
    end

    assign pready_out     = s_reg.pready;
    assign pslverr_out    = s_reg.pslverr;
    assign prdata_out     = s_reg.prdata;
    assign dmem_addr_out  = s_reg.addr;
    assign dmem_wdata_out = s_reg.wdata;
    assign dmem_wr_out    = s_reg.wr;
    assign dmem_rd_out    = s_reg.rd;
    assign pc_out         = s_reg.pc;

endmodule

/* bench/cbe_exec_sva.sv */
// checker for the execution block: apb answer timing, busy and memory strobes
// assumes it is bound to cbe_exec and sees only that module's ports
`timescale 1ns/1ps
module cbe_exec_sva (
    // clock and reset
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    // apb
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic        pready_out,
    // memory and core
    input wire logic        dmem_wr_out,
    input wire logic        dmem_rd_out,
    input wire logic        busy_out,
    input wire logic [15:0] pc_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_pready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no answer after setup");
    a_pready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_pready_in_access: assert property (pready_out |-> psel_in && penable_in)
        else $error("pready outside access phase");
    a_busy_short: assert property ($rose(busy_out) |-> ##[1:2] !busy_out)
        else $error("instruction longer than two cycles");
    a_busy_from_cmd: assert property ($rose(busy_out) |->
        $past(psel_in && penable_in && pwrite_in && pready_out && paddr_in == 12'h000))
        else $error("busy without command write");
    a_strobe_busy: assert property (dmem_rd_out || dmem_wr_out |-> busy_out)
        else $error("memory strobe while idle");
    a_strobe_last: assert property (dmem_rd_out || dmem_wr_out |=> !busy_out)
        else $error("memory strobe not in last cycle");
    a_rd_wr_excl: assert property (!(dmem_rd_out && dmem_wr_out))
        else $error("read and write strobes together");
    a_pc_cause: assert property ($changed(pc_out) |-> $past(busy_out) ||
        $past(psel_in && penable_in && pwrite_in && pready_out && paddr_in == 12'h010))
        else $error("pc moved without instruction");

    c_read: cover property (dmem_rd_out);
    c_write: cover property (dmem_wr_out);
    c_two_cycle: cover property ($rose(busy_out) ##1 busy_out);
endmodule

bind cbe_exec cbe_exec_sva cbe_exec_sva_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pready_out(pready_out), .dmem_wr_out(dmem_wr_out), .dmem_rd_out(dmem_rd_out),
    .busy_out(busy_out), .pc_out(pc_out));

/* bench/cbe_dmem_model.sv */
// data memory model: combinational read while strobed, write at the clock edge
// assumes the bench preloads and inspects mem directly
`timescale 1ns/1ps
module cbe_dmem_model (
    // clock
    input  wire logic        clk_in,
    // memory port
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    // released bus shows the inverse of the last value, never a stale copy
    assign rdata_out = rd_in ? mem[addr_in] : ~last_q;

    always @(posedge clk_in) begin
        if (rd_in) last_q <= mem[addr_in];
        if (wr_in) mem[addr_in] <= wdata_in;
    end
endmodule

/* bench/cbe_exec_tb_top.sv */
// self-checking bench for cbe_exec: branches, copies, loads, stores over apb
// assumes the memory model beside the design and the checker bound to it
`timescale 1ns/1ps
module cbe_exec_tb_top;
    logic        ref_clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
    logic        dmem_wr, dmem_rd, busy, f, tk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] dmem_addr, pc, pc_exp, off;
    logic [7:0]  dmem_wdata, dmem_rdata, fl;
    int          n_errors = 0;
    int          check_count = 0;

    cbe_exec #(.DISP_W(6)) cbe_exec_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
        .dmem_rdata_in(dmem_rdata), .dmem_addr_out(dmem_addr), .dmem_wdata_out(dmem_wdata),
        .dmem_wr_out(dmem_wr), .dmem_rd_out(dmem_rd), .busy_out(busy), .pc_out(pc));
    cbe_dmem_model cbe_dmem_model_i (.clk_in(ref_clk_in), .addr_in(dmem_addr),
        .wdata_in(dmem_wdata), .wr_in(dmem_wr), .rd_in(dmem_rd), .rdata_out(dmem_rdata));

    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic bail;
        n_errors++;
        $display("[FAIL] %0t wait ran out", $time);
        end_sim();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge ref_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) bail();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(wr, a, d, q, e);
        chk({31'h0, e}, {31'h0, exp_err});
        if (!wr) chk(q, exp);
    endtask

    function automatic logic [11:0] ra(input int n);
        return 12'(12'h080 + 4 * n);
    endfunction

    function automatic logic [31:0] cmd(input logic [3:0] op, input logic [4:0] d, r,
                                        input logic [1:0] ptr, md, input logic [2:0] sel,
                                        input logic pol);
        return {10'h000, pol, sel, md, ptr, r, d, op};
    endfunction

    task automatic exec(input logic [31:0] c, input logic [15:0] opd, input int cyc,
                        input int inc);
        int n;
        acc(1'b1, 12'h004, {16'h0000, opd}, 32'h0, 1'b0);
        acc(1'b1, 12'h000, c, 32'h0, 1'b0);
        n = 0;
        do begin
            @(posedge ref_clk_in);
            if (busy === 1'b1) n++;
        end while (busy === 1'b1 && n < 8);
        if (n >= 8) bail();
        chk(n, cyc);
        pc_exp = pc_exp + 16'(inc);
        chk({16'h0000, pc}, {16'h0000, pc_exp});
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        acc(1'b0, 12'h010, 0, 32'h0, 1'b0);
        acc(1'b0, 12'h00C, 0, 32'h0, 1'b0);
        acc(1'b0, 12'h008, 0, 32'h0, 1'b0);
        acc(1'b1, 12'h010, 32'h0000_FFF8, 0, 1'b0);
        pc_exp = 16'hFFF8;
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 8; s++) begin
                for (int pol = 0; pol < 2; pol++) begin
                    fl = p ? 8'h42 : 8'hA5;
                    off = p ? 16'hFFF0 : 16'h0013;
                    f = (s == 4) ? fl[2] ^ fl[3] : fl[s];
                    tk = (f == pol[0]);
                    acc(1'b1, 12'h00C, {24'h0, fl}, 0, 1'b0);
                    exec(cmd(4'h0, 0, 0, 0, 0, 3'(s), pol[0]), off, tk ? 2 : 1,
                         tk ? int'(off) + 1 : 1);
                    acc(1'b0, 12'h008, 0, {30'h0, tk, 1'b0}, 1'b0);
                    acc(1'b0, 12'h00C, 0, {24'h0, fl}, 1'b0);
                end
            end
        end
        exec(cmd(4'h3, 16, 0, 0, 0, 0, 0), 16'h005C, 1, 1);
        acc(1'b1, ra(17), 32'hA3, 0, 1'b0);
        exec(cmd(4'h2, 4, 16, 0, 0, 0, 0), 0, 1, 1);
        acc(1'b0, ra(4), 0, 32'h5C, 1'b0);
        acc(1'b0, ra(5), 0, 32'hA3, 1'b0);
        exec(cmd(4'h1, 2, 17, 0, 0, 0, 0), 0, 1, 1);
        acc(1'b0, ra(2), 0, 32'hA3, 1'b0);
        cbe_dmem_model_i.mem[16'h1234] = 8'h77;
        exec(cmd(4'h4, 3, 0, 0, 0, 0, 0), 16'h1234, 2, 2);
        acc(1'b0, ra(3), 0, 32'h77, 1'b0);
        exec(cmd(4'h6, 0, 3, 0, 0, 0, 0), 16'h2000, 2, 2);
        chk({24'h0, cbe_dmem_model_i.mem[16'h2000]}, 32'h77);
        acc(1'b1, ra(26), 32'hFF, 0, 1'b0);
        cbe_dmem_model_i.mem[16'h00FF] = 8'h11;
        exec(cmd(4'h5, 6, 0, 0, 1, 0, 0), 0, 1, 1);
        acc(1'b0, ra(6), 0, 32'h11, 1'b0);
        acc(1'b0, ra(27), 0, 32'h01, 1'b0);
        cbe_dmem_model_i.mem[16'hFFFF] = 8'h22;
        exec(cmd(4'h5, 7, 0, 1, 2, 0, 0), 0, 2, 1);
        acc(1'b0, ra(7), 0, 32'h22, 1'b0);
        acc(1'b0, ra(29), 0, 32'hFF, 1'b0);
        acc(1'b1, ra(31), 32'h30, 0, 1'b0);
        cbe_dmem_model_i.mem[16'h303F] = 8'h33;
        exec(cmd(4'h5, 8, 0, 2, 3, 0, 0), 16'h003F, 2, 1);
        acc(1'b0, ra(8), 0, 32'h33, 1'b0);
        acc(1'b0, ra(31), 0, 32'h30, 1'b0);
        exec(cmd(4'h7, 0, 3, 1, 1, 0, 0), 0, 1, 1);
        chk({24'h0, cbe_dmem_model_i.mem[16'hFFFF]}, 32'h77);
        acc(1'b0, ra(28), 0, 32'h00, 1'b0);
        exec(cmd(4'h7, 0, 7, 0, 2, 0, 0), 0, 2, 1);
        chk({24'h0, cbe_dmem_model_i.mem[16'h00FF]}, 32'h22);
        acc(1'b0, ra(26), 0, 32'hFF, 1'b0);
        acc(1'b0, 12'h00C, 0, 32'h42, 1'b0);
        acc(1'b1, 12'h040, 32'h1, 0, 1'b1);
        acc(1'b0, 12'h000, 0, 32'h0, 1'b1);
        acc(1'b1, 12'h008, 32'h1, 0, 1'b1);
        acc(1'b1, 12'h000, cmd(4'h5, 0, 0, 3, 1, 0, 0), 0, 1'b1);
        chk({16'h0000, pc}, {16'h0000, pc_exp});
        end_sim();
    end
endmodule
